/* File: shared/qcrb_defs.svh */
// Constants shared by the quad retiming buffer.
`ifndef QCRB_DEFS_SVH
`define QCRB_DEFS_SVH
`define QCRB_CHANNELS 4
`define QCRB_SYNC_STAGES 3
`define QCRB_FLOP_RESET 4'h0
`endif

/* File: shared/qcrb_pkg.sv */
// Types shared by the quad retiming buffer.
package qcrb_pkg;
   // One differential pair: true and complement sides.
   typedef struct packed {
      logic p;
      logic n;
   } qcrb_diff_t;
   // Operating state of the buffer.
   typedef enum logic [2:0] {
      QCRB_OFF  = 3'b001,
      QCRB_PASS = 3'b010,
      QCRB_SYNC = 3'b100
   } qcrb_mode_t;
endpackage

/* File: rtl/qcrb_top.sv */
// Quad channel retiming buffer with pass-through and clocked modes.
`timescale 1ns/1ns
`include "qcrb_defs.svh"
module qcrb_top
   import qcrb_pkg::*;
#(
   parameter int CHANNELS = `QCRB_CHANNELS
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire qcrb_diff_t enable_in,
   input wire qcrb_diff_t select_in,
   input wire qcrb_diff_t link_clk_in,
   input wire qcrb_diff_t [CHANNELS-1:0] data_in,
   output qcrb_diff_t [CHANNELS-1:0] data_out
);
   localparam int STG = `QCRB_SYNC_STAGES;

   // Differential inputs reduce to a level: true high and complement low.
   wire enable_raw = enable_in.p & ~enable_in.n;
   wire select_raw = select_in.p & ~select_in.n;
   wire clk_raw = link_clk_in.p & ~link_clk_in.n;
   wire [CHANNELS-1:0] data_raw;

   // Every pin passes three flops; a change counts once stages 2 and 3
   // agree, so the first stage is read only by the second.
   logic [STG-1:0] en_sh_q;
   logic [STG-1:0] sel_sh_q;
   logic [STG-1:0] clk_sh_q;
   logic [CHANNELS-1:0][STG-1:0] dat_sh_q;
   logic en_q;
   logic sel_q;
   logic clk_q;
   logic [CHANNELS-1:0] dat_q;
   logic [CHANNELS-1:0] cap_q;
   logic [CHANNELS-1:0] out_q;
   logic clk_prev_q;

   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         en_sh_q <= '0;
         sel_sh_q <= '0;
         clk_sh_q <= '0;
         en_q <= 1'b0;
         sel_q <= 1'b0;
         clk_q <= 1'b0;
      end else begin
         en_sh_q <= {en_sh_q[STG-2:0], enable_raw};
         sel_sh_q <= {sel_sh_q[STG-2:0], select_raw};
         clk_sh_q <= {clk_sh_q[STG-2:0], clk_raw};
         if (en_sh_q[1] == en_sh_q[2]) en_q <= en_sh_q[2];
         if (sel_sh_q[1] == sel_sh_q[2]) sel_q <= sel_sh_q[2];
         if (clk_sh_q[1] == clk_sh_q[2]) clk_q <= clk_sh_q[2];
      end
   end

   // Per channel input conversion and synchroniser.
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_ch
         assign data_raw[g] = data_in[g].p & ~data_in[g].n;
         always_ff @(posedge clk_sys_in) begin
            if (!resetn_in) begin
               dat_sh_q[g] <= '0;
               dat_q[g] <= 1'b0;
            end else begin
               dat_sh_q[g] <= {dat_sh_q[g][STG-2:0], data_raw[g]};
               if (dat_sh_q[g][1] == dat_sh_q[g][2]) begin
                  dat_q[g] <= dat_sh_q[g][2];
               end
            end
         end
         // Output pair is always complementary, never both high.
         assign data_out[g] = '{p: out_q[g], n: ~out_q[g]};
      end
   endgenerate

   // Mode decode; enable low overrides everything.
   qcrb_mode_t mode;
   assign mode = !en_q ? QCRB_OFF : (sel_q ? QCRB_PASS : QCRB_SYNC);
   wire clk_rise = clk_q & ~clk_prev_q;

   // Clock edge history tracks the level at all times, so a rise that
   // happened during disable is not seen as a new edge on re-enable.
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         clk_prev_q <= 1'b0;
      end else begin
         clk_prev_q <= clk_q;
      end
   end

   // Capture flops and output register.
   logic [CHANNELS-1:0] cap_d;
   logic [CHANNELS-1:0] out_d;
   always_comb begin
      cap_d = cap_q;
      out_d = out_q;
      case (mode)
         QCRB_OFF: begin
            out_d = '0;
         end
         QCRB_PASS: begin
            out_d = dat_q;
         end
         QCRB_SYNC: begin
            if (clk_rise) cap_d = dat_q;
            out_d = cap_d;
         end
         default: begin
            out_d = '0;
         end
      endcase
   end

   // Reset gives a defined start; the device itself has no reset pin.
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         cap_q <= CHANNELS'(`QCRB_FLOP_RESET);
         out_q <= CHANNELS'(`QCRB_FLOP_RESET);
      end else begin
         cap_q <= cap_d;
         out_q <= out_d;
      end
   end
endmodule

/* File: sim/qcrb_properties.sv */
// Port checker for the quad retiming buffer.
`timescale 1ns/1ns
module qcrb_properties
   import qcrb_pkg::*;
#(parameter int CHANNELS = 4) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire qcrb_diff_t enable_in,
   input wire qcrb_diff_t select_in,
   input wire qcrb_diff_t link_clk_in,
   input wire qcrb_diff_t [CHANNELS-1:0] data_in,
   input wire qcrb_diff_t [CHANNELS-1:0] data_out
);
   // A pair reads high only as {1,0}; windows span the five-edge path.
   wire en = enable_in == 2'h2, ck = link_clk_in == 2'h2;
   wire ps = en && select_in == 2'h2, sy = en && !ps;
   wire [2*CHANNELS-1:0] o = data_out, d = data_in, lo = {CHANNELS{2'h1}};
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   a_off_low: assert property (!en[*7] |-> o==lo) else $error("lo");
   a_off_frozen: assert property (!en[*8] |-> $stable(o))
      else $error("frozen");
   a_pass_follow: assert property ((ps && $stable(d))[*7] |-> o==d)
      else $error("pass");
   a_pass_noclk: assert property
      ((ps && $stable(d))[*8] |-> $stable(o)) else $error("noclk");
   a_sync_hold: assert property ((sy && !ck)[*8] |-> $stable(o))
      else $error("hold");
   a_sync_cap: assert property ((sy && !ck && $stable(d))[*6] ##1
      (sy && ck && $stable(d))[*7] |-> o==d) else $error("cap");
   a_diff_pair: assert property ((((o >> 1) ^ o) & lo) == lo)
      else $error("pair");
   a_on_drive: assert property ($rose(en) ##1
      (ps && $stable(d))[*7] |-> o==d) else $error("drive");
   cover property (!en[*8]);
   cover property (sy && $rose(ck));
   cover property (ps && $rose(ck));
endmodule
bind qcrb_top qcrb_properties #(.CHANNELS(CHANNELS)) u_props (.*);

/* File: sim/qcrb_src.sv */
// Far-side model: the link clock driver.
`timescale 1ns/1ns
module qcrb_src (
   input wire logic clk_sys_in,
   input wire logic run_in,
   output logic [1:0] link_clk_out
);
   logic [3:0] cnt_q = 4'h0;
   // Eight-cycle phases; parked low when idle to limit coupling.
   always_ff @(posedge clk_sys_in) begin
      cnt_q <= run_in ? cnt_q + 4'h1 : 4'h0;
   end
   assign link_clk_out = {cnt_q[3], ~cnt_q[3]};
endmodule

/* File: sim/quad_channel_retiming_buffer_tb_top.sv */
// Bench for the quad retiming buffer.
`timescale 1ns/1ns
module quad_channel_retiming_buffer_tb_top;
   logic clk_sys_in = 1'b0, resetn_in = 1'b0, run = 1'b0;
   logic [1:0] en = 2'h1, sel = 2'h2, ck;
   logic [7:0] din = 8'h55, dout;
   int miscompares = 0, n_tests = 0;
   always #10 clk_sys_in = ~clk_sys_in;
   qcrb_src u_src (.clk_sys_in, .run_in(run), .link_clk_out(ck));
   qcrb_top u_dut (.clk_sys_in, .resetn_in, .enable_in(en),
      .select_in(sel), .link_clk_in(ck), .data_in(din), .data_out(dout));
   // Apply a setting at a falling edge, then let n cycles pass.
   task automatic go(int n, logic [1:0] e, s, logic r, logic [7:0] v);
      @(negedge clk_sys_in);
      {en, sel, run, din} = {e, s, r, v};
      repeat (n) @(negedge clk_sys_in);
   endtask
   task automatic check(string s, logic [7:0] v, x);
      n_tests++;
      miscompares += (v !== x);
      if (v !== x) $display("ERROR %s exp %h got %h", s, x, v);
   endtask
   // Pass mode with the link clock toggling on purpose.
   task automatic t_pass;
      go(9, 2'h2, 2'h2, 1'b1, 8'h99);
      check("pass", dout, 8'h99);
      go(9, 2'h2, 2'h2, 1'b1, 8'h66);
      check("noclk", dout, 8'h66);
   endtask
   // Capture flops start cleared, so sync shows low until a rise.
   task automatic t_sync;
      go(9, 2'h2, 2'h1, 1'b0, 8'h99);
      check("hold", dout, 8'h55);
      go(17, 2'h2, 2'h1, 1'b1, 8'h99);
      go(9, 2'h2, 2'h1, 1'b0, 8'h5A);
      check("cap", dout, 8'h99);
   endtask
   // Everything toggles while off; nothing may be replayed after.
   task automatic t_off;
      go(6, 2'h1, 2'h1, 1'b0, 8'h99);
      go(12, 2'h1, 2'h2, 1'b1, 8'hA5);
      go(9, 2'h1, 2'h1, 1'b0, 8'h69);
      check("off", dout, 8'h55);
      go(9, 2'h2, 2'h1, 1'b0, 8'h69);
      check("frozen", dout, 8'h99);
   endtask
   task automatic summarize;
      if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence; the watchdog allows about four times its length.
   initial begin
      repeat (3) @(negedge clk_sys_in);
      resetn_in = 1'b1;
      t_pass();
      t_sync();
      t_off();
      summarize();
   end
   initial begin
      #8000;
      miscompares++;
      summarize();
   end
endmodule
